// ==== src/spi_slave_port_with_attention.sv ====
// system-side control of the spi slave port with attention line
// assumes a mode 0 host master; pins arrive unsynchronised
`timescale 1ns/1ns
module spi_slave_port_with_attention (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        spi_clk,
  input  wire logic        chip_select_low,
  input  wire logic        mosi,
  output logic             miso,
  output logic             miso_oe_n,
  output logic             attention_n,
  input  wire logic        uart_rx_pin,
  input  wire logic        uart_tx_force_serial_periph,
  input  wire logic        uart_enable,
  input  wire logic        spi_enable,
  input  wire logic        sleep_pin_function,
  input  wire logic        sleep_request_pin,
  input  wire logic        select_pin_setting,
  input  wire logic        pin_sleep_mode,
  input  wire logic [2:0]  attention_pin_setting,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  output logic [7:0]       uart_tx_byte,
  output logic             uart_tx_stb,
  output logic [7:0]       rx_data,
  output logic             rx_valid,
  output logic             rx_in_frame,
  output logic [1:0]       active_port,
  output logic             spi_pins_forced,
  output logic [2:0]       attention_setting_eff,
  output logic             uart_cmd_mode_force,
  output logic [13:0]      uart_baud_force,
  output logic             status_frame_req,
  output logic             sleep_now
);
  spi_att_pkg::phase_t phase;      // startup phase
  spi_att_pkg::port_t  port;       // chosen serial port
  spi_att_pkg::rxst_t  rxst;       // receive delimiting state
  logic [1:0]  strap_cnt;          // wait for synchronisers
  logic [2:0]  sel_sync;           // select: two stages plus edge history
  logic [2:0]  urx_sync;           // uart rx: two stages plus edge history
  logic [1:0]  dout_sync;          // uart tx strap synchroniser
  logic [1:0]  slp_sync;           // sleep request synchroniser
  logic [1:0]  ack_sync;           // link ack toggle synchroniser
  logic [1:0]  busy_sync;          // link busy level synchroniser
  logic [3:0]  rtog_sync;          // rx toggle: three stages plus history
  logic [7:0]  tx_hold;            // byte offered to the link
  logic        tx_req;             // offer toggle
  logic        tx_ack;             // link ack toggle, link domain
  logic        out_busy;           // link shifter holds data
  logic [7:0]  link_rx_byte;       // last byte from link
  logic        link_rx_tog;        // byte posted toggle
  logic        link_miso;          // serial data from shifter
  logic        sel_fall;           // select asserted this cycle
  logic        urx_fall;           // uart input started
  logic        rx_new;             // new byte from link
  logic        spi_take;           // byte accepted for spi
  logic [15:0] rx_left;            // bytes still owed by frame

  // shifter on the host clock; link reset is system reset
  spi_link_shifter u_shift (
    .spi_clk         (spi_clk),
    .link_rst        (sys_rst),
    .chip_select_low (chip_select_low),
    .mosi            (mosi),
    .miso_bit        (link_miso),
    .tx_hold         (tx_hold),
    .tx_req          (tx_req),
    .tx_ack          (tx_ack),
    .out_busy        (out_busy),
    .rx_byte         (link_rx_byte),
    .rx_tog          (link_rx_tog)
  );

  // pin and cross-domain synchronisers; first stage read only by second
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sel_sync  <= 3'h7;
      urx_sync  <= 3'h7;
      dout_sync <= 2'h3;
      slp_sync  <= 2'h3;
      ack_sync  <= 2'h0;
      busy_sync <= 2'h0;
      rtog_sync <= 4'h0;
    end else begin
      sel_sync  <= {sel_sync[1:0], chip_select_low};
      urx_sync  <= {urx_sync[1:0], uart_rx_pin};
      dout_sync <= {dout_sync[0], uart_tx_force_serial_periph};
      slp_sync  <= {slp_sync[0], sleep_request_pin};
      ack_sync  <= {ack_sync[0], tx_ack};
      busy_sync <= {busy_sync[0], out_busy};
      rtog_sync <= {rtog_sync[2:0], link_rx_tog};
    end
  end

  assign sel_fall = sel_sync[2] & ~sel_sync[1];
  assign urx_fall = urx_sync[2] & ~urx_sync[1];
  assign rx_new   = rtog_sync[3] ^ rtog_sync[2];

  // strap capture once synchronisers hold real pin levels
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      phase     <= spi_att_pkg::ST_STRAP;
      strap_cnt <= 2'h0;
    end else begin
      case (phase)
        spi_att_pkg::ST_STRAP: begin
          strap_cnt <= strap_cnt + 2'h1;
          if (strap_cnt == spi_att_pkg::STRAP_WAIT)
            phase <= spi_att_pkg::ST_RUN;
        end
        spi_att_pkg::ST_RUN: phase <= spi_att_pkg::ST_RUN;
        default: phase <= spi_att_pkg::ST_STRAP;
      endcase
    end
  end

  // port choice; forced settings are held only until the next reset
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      port                <= spi_att_pkg::PORT_WAIT;
      spi_pins_forced     <= 1'b0;
      uart_cmd_mode_force <= 1'b0;
      uart_baud_force     <= 14'h0000;
      status_frame_req    <= 1'b0;
    end else begin
      status_frame_req <= 1'b0;
      if (phase == spi_att_pkg::ST_STRAP && strap_cnt == spi_att_pkg::STRAP_WAIT) begin
        if (!dout_sync[1]) begin
          port             <= spi_att_pkg::PORT_SPI;
          spi_pins_forced  <= 1'b1;
          status_frame_req <= 1'b1;
        end else if (!urx_sync[1]) begin
          port                <= spi_att_pkg::PORT_UART;
          uart_cmd_mode_force <= 1'b1;
          uart_baud_force     <= spi_att_pkg::UART_FORCE_BAUD;
        end else begin
          case ({uart_enable, spi_enable})
            2'b11:   port <= spi_att_pkg::PORT_WAIT;
            2'b10:   port <= spi_att_pkg::PORT_UART;
            2'b01:   port <= spi_att_pkg::PORT_SPI;
            default: port <= spi_att_pkg::PORT_NONE;
          endcase
        end
      end else if (phase == spi_att_pkg::ST_RUN && port == spi_att_pkg::PORT_WAIT) begin
        // select wins a tie; it also counts as the first spi input
        if (sel_fall)
          port <= spi_att_pkg::PORT_SPI;
        else if (urx_fall)
          port <= spi_att_pkg::PORT_UART;
      end
    end
  end

  assign active_port = port;

  // attention keeps a nonzero setting; zero is replaced when forced
  assign attention_setting_eff = (spi_pins_forced && attention_pin_setting == 3'h0) ?
                                 spi_att_pkg::ATTN_FUNC : attention_pin_setting;

  // spi accepts one byte per free offer slot; other routes stall only until the strap phase ends
  assign spi_take = (port == spi_att_pkg::PORT_SPI) && (ack_sync[1] == tx_req);
  always_comb begin
    case (port)
      spi_att_pkg::PORT_SPI:  tx_ready = phase == spi_att_pkg::ST_RUN && ack_sync[1] == tx_req;
      spi_att_pkg::PORT_UART: tx_ready = phase == spi_att_pkg::ST_RUN;
      spi_att_pkg::PORT_WAIT: tx_ready = phase == spi_att_pkg::ST_RUN;
      default:                tx_ready = 1'b1;
    endcase
  end

  // offer to the link: hold stays stable until acknowledged
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tx_hold <= 8'h00;
      tx_req  <= 1'b0;
    end else if (tx_valid && tx_ready && spi_take) begin
      tx_hold <= tx_data;
      tx_req  <= ~tx_req;
    end
  end

  // uart route, including output before the first input
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      uart_tx_byte <= 8'h00;
      uart_tx_stb  <= 1'b0;
    end else begin
      uart_tx_stb <= tx_valid && tx_ready &&
                     (port == spi_att_pkg::PORT_UART || port == spi_att_pkg::PORT_WAIT);
      if (tx_valid && tx_ready)
        uart_tx_byte <= tx_data;
    end
  end

  // attention from offer, in-flight and shifter state; a short
  // tail of a few cycles follows the last bit through the crossing
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst)
      attention_n <= 1'b1;
    else
      attention_n <= !((port == spi_att_pkg::PORT_SPI) &&
                       ((tx_valid) || (tx_req != ack_sync[1]) || busy_sync[1]));
  end

  // miso driven only while selected and the spi port is in use
  assign miso      = link_miso;
  assign miso_oe_n = chip_select_low || (port != spi_att_pkg::PORT_SPI);

  // pin sleep source choice
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst)
      sleep_now <= 1'b0;
    else if (!pin_sleep_mode)
      sleep_now <= 1'b0;
    else if (sleep_pin_function)
      sleep_now <= slp_sync[1];
    else if (select_pin_setting)
      sleep_now <= sel_sync[1];
    else
      sleep_now <= 1'b0;
  end

  // receive delimiting: only bytes of a frame are passed on
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rxst        <= spi_att_pkg::RX_IDLE;
      rx_left     <= 16'h0000;
      rx_data     <= 8'h00;
      rx_valid    <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (rx_new && port == spi_att_pkg::PORT_SPI) begin
        case (rxst)
          spi_att_pkg::RX_IDLE: begin
            if (link_rx_byte == spi_att_pkg::START_DELIM) begin
              rxst     <= spi_att_pkg::RX_LENH;
              rx_data  <= link_rx_byte;
              rx_valid <= 1'b1;
            end
          end
          spi_att_pkg::RX_LENH: begin
            rx_left[15:8] <= link_rx_byte;
            rxst          <= spi_att_pkg::RX_LENL;
            rx_data       <= link_rx_byte;
            rx_valid      <= 1'b1;
          end
          spi_att_pkg::RX_LENL: begin
            // payload plus one checksum byte follows
            rx_left  <= {rx_left[15:8], link_rx_byte} + 16'h0001;
            rxst     <= spi_att_pkg::RX_BODY;
            rx_data  <= link_rx_byte;
            rx_valid <= 1'b1;
          end
          spi_att_pkg::RX_BODY: begin
            rx_left  <= rx_left - 16'h0001;
            rx_data  <= link_rx_byte;
            rx_valid <= 1'b1;
            if (rx_left == 16'h0001)
              rxst <= spi_att_pkg::RX_IDLE;
          end
          default: rxst <= spi_att_pkg::RX_IDLE;
        endcase
      end
    end
  end

  assign rx_in_frame = rxst != spi_att_pkg::RX_IDLE;

  // assertions
  sequence forced_start_s;
    phase == spi_att_pkg::ST_STRAP && strap_cnt == spi_att_pkg::STRAP_WAIT && !dout_sync[1];
  endsequence
  sequence spi_only_s;
    port == spi_att_pkg::PORT_SPI && spi_pins_forced;
  endsequence

  forced_spi_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    forced_start_s |=> spi_only_s and status_frame_req)
    else $error("forced spi start not taken");

  attn_queue_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (port == spi_att_pkg::PORT_SPI && tx_valid) |=> !attention_n)
    else $error("attention idle with data queued");

  attn_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (port == spi_att_pkg::PORT_SPI && busy_sync[1]) |=> !attention_n)
    else $error("attention dropped before shift out");

  miso_release_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    chip_select_low |-> miso_oe_n)
    else $error("miso driven while deselected");

  first_select_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (phase == spi_att_pkg::ST_RUN && port == spi_att_pkg::PORT_WAIT && sel_fall) |=>
      port == spi_att_pkg::PORT_SPI [*2])
    else $error("first select did not claim spi");

  no_port_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    port == spi_att_pkg::PORT_NONE |-> tx_ready && !uart_tx_stb)
    else $error("data not discarded without port");

  sleep_sel_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pin_sleep_mode && !sleep_pin_function && select_pin_setting) |=> sleep_now == $past(sel_sync[1]))
    else $error("select does not drive pin sleep");

  never_sleep_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!sleep_pin_function && !select_pin_setting) |=> !sleep_now)
    else $error("slept with no sleep pin");

  attn_force_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (spi_pins_forced && attention_pin_setting != 3'h0) |-> attention_setting_eff == attention_pin_setting)
    else $error("nonzero attention setting overridden");
endmodule : spi_slave_port_with_attention

// ==== src/spi_att_pkg.sv ====
// constants shared by the spi slave port with attention line
// assumes a 50 MHz system clock and a host spi master in mode 0
// Operation
// - attention low while output data queued
// - miso shifts while selected, released otherwise
// - full duplex; frames mark valid content
// - both directions valid simultaneously, sustained
// - sleep pin, if peripheral, controls sleep
// - else select low wakes, high sleeps
// - neither peripheral: never pin sleep
// - both ports: uart until first select
// - single enabled port used exclusively
// - no port: discard all outgoing data
// - uart rx low at reset: default uart
// - uart tx strap forces spi only
// - forced spi start queues status frame
// - force spi pins; attention only if zero
// - forced settings last this session only
// - first port with input wins
// - empty output repeats last sent bit
// - frames sent raw, no byte escaping
// - mode zero, msb first
// - attention held until all clocked out
package spi_att_pkg;
  // strap sampling waits for the pin synchronisers to fill
  localparam logic [1:0]  STRAP_WAIT      = 2'h3;
  // default uart rate used by the forced uart start
  localparam logic [13:0] UART_FORCE_BAUD = 14'h2580;
  // attention-pin setting that means serial attention function
  localparam logic [2:0]  ATTN_FUNC       = 3'h1;
  // frame start byte; plain default, checked on receive only
  localparam logic [7:0]  START_DELIM     = 8'h7E;

  // startup sequence of the system side
  typedef enum logic [1:0] {
    ST_STRAP = 2'b00,
    ST_RUN   = 2'b01
  } phase_t;

  // which serial port carries traffic
  typedef enum logic [1:0] {
    PORT_WAIT = 2'b00,
    PORT_UART = 2'b01,
    PORT_SPI  = 2'b10,
    PORT_NONE = 2'b11
  } port_t;

  // receive frame delimiting
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_LENH = 2'b01,
    RX_LENL = 2'b10,
    RX_BODY = 2'b11
  } rxst_t;
endpackage : spi_att_pkg

// ==== src/spi_link_shifter.sv ====
// byte shifter running on the master's serial clock
// assumes mode 0 and that the clock stands still outside frames
`timescale 1ns/1ns
module spi_link_shifter (
  input  wire logic       spi_clk,
  input  wire logic       link_rst,
  input  wire logic       chip_select_low,
  input  wire logic       mosi,
  output logic            miso_bit,
  input  wire logic [7:0] tx_hold,
  input  wire logic       tx_req,
  output logic            tx_ack,
  output logic            out_busy,
  output logic [7:0]      rx_byte,
  output logic            rx_tog
);
  logic       frame_rst;   // counters restart on every deselect
  logic [2:0] rx_cnt;      // rising edges in current byte
  logic [6:0] rx_sh;       // partial receive byte
  logic [2:0] tx_cnt;      // falling edges in current byte
  logic [7:0] tx_sh;       // bits still to present
  logic       req_s1;      // request synchroniser, first stage
  logic       req_s2;      // request synchroniser, second stage

  assign frame_rst = link_rst | chip_select_low;
  assign miso_bit  = tx_sh[7];

  // receive: sample mosi on rising edge, msb first
  always_ff @(posedge spi_clk or posedge frame_rst) begin
    if (frame_rst) begin
      rx_cnt <= 3'h0;
      rx_sh  <= 7'h00;
    end else begin
      rx_cnt <= rx_cnt + 3'h1;
      rx_sh  <= {rx_sh[5:0], mosi};
    end
  end

  // receive word and toggle survive deselect for the crossing
  always_ff @(posedge spi_clk or posedge link_rst) begin
    if (link_rst) begin
      rx_byte <= 8'h00;
      rx_tog  <= 1'b0;
    end else if (!chip_select_low && rx_cnt == 3'h7) begin
      rx_byte <= {rx_sh, mosi};
      rx_tog  <= ~rx_tog;
    end
  end

  // request toggle synchroniser on the launch edge
  always_ff @(negedge spi_clk or posedge link_rst) begin
    if (link_rst) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
    end else begin
      req_s1 <= tx_req;
      req_s2 <= req_s1;
    end
  end

  // bit position counter, restarts on deselect
  always_ff @(negedge spi_clk or posedge frame_rst) begin
    if (frame_rst)
      tx_cnt <= 3'h0;
    else
      tx_cnt <= tx_cnt + 3'h1;
  end

  // transmit: change data on falling edge, load at byte end
  always_ff @(negedge spi_clk or posedge link_rst) begin
    if (link_rst) begin
      tx_sh    <= 8'h00;
      tx_ack   <= 1'b0;
      out_busy <= 1'b0;
    end else if (tx_cnt == 3'h7 || chip_select_low) begin
      if (req_s2 != tx_ack) begin
        tx_sh    <= tx_hold;
        tx_ack   <= ~tx_ack;
        out_busy <= 1'b1;
      end else begin
        tx_sh    <= {8{tx_sh[0]}};
        out_busy <= 1'b0;
      end
    end else begin
      tx_sh <= {tx_sh[6:0], tx_sh[0]};
    end
  end

  // idle fill keeps the last bit at the pin
  property idle_repeat_p;
    @(negedge spi_clk) disable iff (link_rst)
      (tx_cnt == 3'h7 && req_s2 == tx_ack) |=> (miso_bit == $past(tx_sh[0]));
  endproperty
  idle_fill_a: assert property (idle_repeat_p) else $error("idle fill lost last bit");

  // a loaded byte shows its msb first
  msb_first_a: assert property (@(negedge spi_clk) disable iff (link_rst)
    (tx_cnt == 3'h7 && !chip_select_low && req_s2 != tx_ack) |=> (miso_bit == $past(tx_hold[7])))
    else $error("loaded byte not msb first");

  // receive toggle flips once per eight rising edges
  rx_byte_a: assert property (@(posedge spi_clk) disable iff (link_rst)
    (rx_cnt == 3'h7 && !chip_select_low) |=> (rx_tog != $past(rx_tog)))
    else $error("received byte not posted");
endmodule : spi_link_shifter

// ==== dv/spi_host_model.sv ====
// host spi master model driving the attention port from outside
// assumes mode 0; the 12 ns link clock runs only inside frames
`timescale 1ns/1ns
module spi_host_model (
  output logic      spi_clk,
  output logic      chip_select_low,
  output logic      mosi,
  input  wire logic miso
);
  // idle state: clock parked low, device not selected
  initial begin
    spi_clk = 1'b0;
    chip_select_low = 1'b1;
    mosi = 1'b1;
  end

  // select or release; select inverts the data line, release waits 6 ns
  task sel(input logic low);
    chip_select_low = low;
    if (low) #6;
    else mosi = ~mosi;
  endtask : sel

  // one byte each way, msb first, data set while the clock is low
  task xfer(input logic [7:0] o, output logic [7:0] i);
    for (int b = 7; b >= 0; b--) begin
      mosi = o[b];
      #6 spi_clk = 1'b1;
      i[b] = miso;
      #6 spi_clk = 1'b0;
    end
  endtask : xfer
endmodule : spi_host_model

// ==== dv/test_spi_slave_port_with_attention.sv ====
// self-checking bench for the spi slave port with attention line
// assumes the host model sits on the link pins; config bits are plain inputs
`timescale 1ns/1ns
`define CK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin fails++; \
  $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module test_spi_slave_port_with_attention;
  logic clk_sys, sys_rst, uart_rx_pin, uart_tx_force_serial_periph;
  logic uart_enable, spi_enable, sleep_pin_function, sleep_request_pin;
  logic select_pin_setting, pin_sleep_mode, tx_valid;
  logic [2:0] attention_pin_setting, attention_setting_eff;
  logic [7:0] tx_data, uart_tx_byte, rx_data, last_stb, b;
  logic miso, miso_oe_n, attention_n, tx_ready, uart_tx_stb, rx_valid, rx_in_frame;
  logic [1:0] active_port;
  logic spi_pins_forced, uart_cmd_mode_force, status_frame_req, sleep_now;
  logic [13:0] uart_baud_force;
  wire logic spi_clk, chip_select_low, mosi;
  int fails, n_compared, n_stb, n_stat;
  logic [7:0] rxq[$];

  spi_slave_port_with_attention uut (.clk_sys, .sys_rst, .spi_clk, .chip_select_low, .mosi, .miso,
    .miso_oe_n, .attention_n, .uart_rx_pin, .uart_tx_force_serial_periph, .uart_enable, .spi_enable,
    .sleep_pin_function, .sleep_request_pin, .select_pin_setting, .pin_sleep_mode,
    .attention_pin_setting, .tx_data, .tx_valid, .tx_ready, .uart_tx_byte, .uart_tx_stb, .rx_data,
    .rx_valid, .rx_in_frame, .active_port, .spi_pins_forced, .attention_setting_eff,
    .uart_cmd_mode_force, .uart_baud_force, .status_frame_req, .sleep_now);
  // a released miso line shows the inverse, so a missing enable is caught
  spi_host_model host (.spi_clk, .chip_select_low, .mosi, .miso(miso_oe_n ? ~miso : miso));

  // 50 MHz system clock
  initial clk_sys = 1'b0;
  always #10 clk_sys = ~clk_sys;

  // tally pulses and received bytes mid-cycle, away from the launching edge
  always @(negedge clk_sys) begin
    if (uart_tx_stb === 1'b1) begin
      n_stb++;
      last_stb = uart_tx_byte;
    end
    if (status_frame_req === 1'b1) n_stat++;
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
  end

  // step n edges, then land just after the edge
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : cyc

  task final_report;
    if (fails == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // reset with a given config; straps held well past their sampling edge
  task rst(input logic ue, se, rxp, txp, input logic [2:0] aset);
    uart_enable = ue;
    spi_enable = se;
    uart_rx_pin = rxp;
    uart_tx_force_serial_periph = txp;
    attention_pin_setting = aset;
    sys_rst = 1'b1;
    n_stat = 0;
    cyc(5);
    `CK("attn_rst", 1'b1, attention_n)
    `CK("oe_rst", 1'b1, miso_oe_n)
    sys_rst = 1'b0;
    cyc(8);
    uart_rx_pin = 1'b1;
    uart_tx_force_serial_periph = 1'b1;
  endtask : rst

  // hand one byte over, waiting a bounded time for ready
  task tx_put(input logic [7:0] v);
    for (int k = 0; k < 200 && tx_ready !== 1'b1; k++) cyc(1);
    `CK("tx_ready", 1'b1, tx_ready)
    tx_data = v;
    tx_valid = 1'b1;
    cyc(1);
    tx_valid = 1'b0;
  endtask : tx_put

  // both ports: uart carries output until the first select
  task t_uart_first;
    n_stb = 0;
    `CK("port_wait", 2'h0, active_port)
    tx_put(8'h3C);
    cyc(3);
    `CK("uart_cnt", 1, n_stb)
    `CK("uart_byte", 8'h3C, last_stb)
    host.sel(1'b0);
    cyc(6);
    `CK("port_spi", 2'h2, active_port)
    `CK("oe_sel", 1'b0, miso_oe_n)
    host.sel(1'b1);
    cyc(2);
    `CK("oe_desel", 1'b1, miso_oe_n)
  endtask : t_uart_first

  // spi output, attention life cycle, idle repeat of last bit
  task t_spi_tx(input logic [7:0] v);
    logic hit;
    hit = 1'b0;
    tx_put(v);
    cyc(2);
    `CK("attn_on", 1'b0, attention_n)
    `CK("held_off", 1'b0, tx_ready)
    host.sel(1'b0);
    for (int k = 0; k < 4 && !hit; k++) begin
      host.xfer(8'h00, b);
      hit = (b === v);
    end
    `CK("miso_byte", 1'b1, hit)
    host.xfer(8'h00, b);
    `CK("idle_rep", {8{v[0]}}, b)
    host.sel(1'b1);
    cyc(10);
    `CK("attn_off", 1'b1, attention_n)
  endtask : t_spi_tx

  // receive a frame behind junk while a reply byte goes out
  task t_rx_frame;
    logic [7:0] f[6];
    logic seen;
    f = '{8'h33, 8'h7E, 8'h00, 8'h01, 8'hAB, 8'hCD};
    seen = 1'b0;
    rxq.delete();
    tx_put(8'hC3);
    host.sel(1'b0);
    foreach (f[i]) begin
      if (i == 5) `CK("in_frame", 1'b1, rx_in_frame)
      host.xfer(f[i], b);
      if (b === 8'hC3) seen = 1'b1;
    end
    host.sel(1'b1);
    cyc(10);
    `CK("rx_count", 5, rxq.size())
    `CK("frame_end", 1'b0, rx_in_frame)
    for (int i = 0; i < 5 && i < rxq.size(); i++) `CK("rx_byte", f[i+1], rxq[i])
    `CK("duplex", 1'b1, seen)
  endtask : t_rx_frame

  // which pin steers pin sleep
  task t_sleep;
    pin_sleep_mode = 1'b1;
    sleep_pin_function = 1'b1;
    select_pin_setting = 1'b1;
    sleep_request_pin = 1'b1;
    cyc(6);
    `CK("slp_pin", 1'b1, sleep_now)
    sleep_request_pin = 1'b0;
    cyc(6);
    `CK("wake_pin", 1'b0, sleep_now)
    sleep_pin_function = 1'b0;
    cyc(6);
    `CK("slp_sel", 1'b1, sleep_now)
    host.sel(1'b0);
    cyc(6);
    `CK("wake_sel", 1'b0, sleep_now)
    host.sel(1'b1);
    select_pin_setting = 1'b0;
    cyc(6);
    `CK("no_sleep", 1'b0, sleep_now)
  endtask : t_sleep

  // port choice under each enable combination, and each strap with both ports enabled
  task t_ports;
    rst(1'b1, 1'b0, 1'b1, 1'b1, 3'h0);
    host.sel(1'b0);
    cyc(6);
    `CK("uart_only", 2'h1, active_port)
    `CK("oe_uart", 1'b1, miso_oe_n)
    host.sel(1'b1);
    rst(1'b0, 1'b1, 1'b1, 1'b1, 3'h0);
    `CK("spi_only", 2'h2, active_port)
    rst(1'b0, 1'b0, 1'b1, 1'b1, 3'h0);
    n_stb = 0;
    `CK("no_port", 2'h3, active_port)
    tx_put(8'h11);
    cyc(3);
    `CK("dropped", 0, n_stb)
    rst(1'b1, 1'b1, 1'b0, 1'b1, 3'h0);
    `CK("cmd_mode", 1'b1, uart_cmd_mode_force)
    `CK("baud", spi_att_pkg::UART_FORCE_BAUD, uart_baud_force)
    rst(1'b1, 1'b1, 1'b1, 1'b0, 3'h0);
    `CK("forced_spi", 2'h2, active_port)
    `CK("pins_forced", 1'b1, spi_pins_forced)
    `CK("attn_func", spi_att_pkg::ATTN_FUNC, attention_setting_eff)
    `CK("status_req", 1, n_stat)
    rst(1'b1, 1'b1, 1'b1, 1'b0, 3'h2);
    `CK("attn_kept", 3'h2, attention_setting_eff)
    rst(1'b1, 1'b1, 1'b1, 1'b1, 3'h2);
    `CK("reverted", 1'b0, spi_pins_forced)
    uart_rx_pin = 1'b0;
    cyc(6);
    host.sel(1'b0);
    cyc(6);
    `CK("uart_won", 2'h1, active_port)
    host.sel(1'b1);
    uart_rx_pin = 1'b1;
  endtask : t_ports

  // hang guard, sized well above the whole sequence
  initial begin
    #400000;
    fails++;
    final_report;
  end

  // main sequence
  initial begin
    fails = 0;
    n_compared = 0;
    n_stb = 0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    sleep_pin_function = 1'b0;
    sleep_request_pin = 1'b0;
    select_pin_setting = 1'b0;
    pin_sleep_mode = 1'b0;
    rst(1'b1, 1'b1, 1'b1, 1'b1, 3'h0);
    t_uart_first;
    t_spi_tx(8'hA5);
    t_spi_tx(8'h5A);
    t_rx_frame;
    t_sleep;
    t_ports;
    final_report;
  end
endmodule : test_spi_slave_port_with_attention
